/* File: verilog/hpn_map.svh */
`ifndef HPN_MAP_SVH
`define HPN_MAP_SVH
// ----------------------------------------------------------------------
// Event bit positions and timing constants.
// ----------------------------------------------------------------------
`define HPN_NUM_EVENTS 6
`define HPN_EV_ATTN 0
`define HPN_EV_PFAULT 1
`define HPN_EV_MRL 2
`define HPN_EV_PRES 3
`define HPN_EV_CMD 4
`define HPN_EV_LINK 5
`define HPN_CLK_HZ 10000000
`define HPN_INSERT_LIMIT_MS 1000
`define HPN_INSERT_LIMIT_CYC ((`HPN_CLK_HZ / 1000) * `HPN_INSERT_LIMIT_MS)
`define HPN_MSI_PULSE_CYC 1
`endif

/* File: verilog/hpn_pkg.sv */
`default_nettype none
package hpn_pkg;
   // Interrupt delivery mode.
   typedef enum logic [1:0] {HPN_MODE_OFF, HPN_MODE_INTX, HPN_MODE_MSI} hpn_mode_t;
   // Device power state.
   typedef enum logic [1:0] {HPN_D0, HPN_D1, HPN_D2, HPN_D3HOT} hpn_dstate_t;
endpackage
`default_nettype wire

/* File: verilog/hpn_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Three-stage synchroniser; output changes once stages two and three agree.
// ----------------------------------------------------------------------
module hpn_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // The first stage is read only by the second stage.
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // Filter: accept a new level only when two stages agree.
         always_ff @(posedge clk) begin
            if (rst) begin
               q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
               q[i] <= s3_q[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* File: verilog/hpn_notify.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hpn_map.svh"
// Functional notes
// - Port implements link-state-changed event with software notification.
// - Link-changed status sets on any change of the link-up indicator.
// - Link-changed event must follow the insertion trigger within one second.
// - Interrupt capable; each event has its own enable and status.
// - A disabled event type never raises an interrupt.
// - Clear global enable suppresses all hot-plug interrupts.
// - Already pending event produces no fresh interrupt.
// - INTx level stays high while enabled status remains set.
// - MSI mode sends one message per enabled status rising edge.
// - Optional message on re-enable while events remain pending.
// - Port signals wakeup for events while asleep or in D1-D3hot.
// - Wake when enabled status rises, low power state, wake enable set.
// - Wake gating uses per-event enables, not the global enable.
// - Port generates wakeup itself, independent of device power.
// - Event pends until cleared; repeats ignored; others still monitored.
module hpn_notify #(
   parameter int N = `HPN_NUM_EVENTS,
   parameter int INSERT_LIMIT_CYC = `HPN_INSERT_LIMIT_CYC,
   parameter bit REENABLE_MSG = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_active,
   input wire logic [N-1:0] slot_event_pin,
   input wire logic [N-1:0] event_enable,
   input wire logic [N-1:0] status_clear,
   input wire logic hp_int_enable,
   input wire hpn_pkg::hpn_mode_t int_mode,
   input wire hpn_pkg::hpn_dstate_t dstate,
   input wire logic system_sleep,
   input wire logic wake_request_enable,
   input wire logic wake_required,
   input wire logic power_ctrl_present,
   input wire logic power_on_cmd,
   output logic [N-1:0] status,
   output logic link_active_out,
   output logic intx_assert,
   output logic msi_req,
   output logic wake_req,
   output logic insert_timeout
);
   // ------------------------------------------------------------------
   // Input synchronisation and event detection.
   // ------------------------------------------------------------------
   logic [N-1:0] pin_sync;
   logic [N-1:0] pin_prev_q;
   logic link_prev_q;
   logic [N-1:0] raw_evt;
   logic [N-1:0] set_evt;
   logic [N-1:0] status_q;
   logic [N-1:0] status_d;
   logic hp_en_prev_q;

   hpn_sync #(.W(N)) u_sync (
      .clk(clk),
      .rst(rst),
      .d(slot_event_pin),
      .q(pin_sync)
   );

   // Edge history for slot pins and the link-up indicator.
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_prev_q <= '0;
         link_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= pin_sync;
         link_prev_q <= link_active;
      end
   end

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_evt
         if (i == `HPN_EV_LINK) begin : g_link
            // Either direction of link-up change is an event.
            assign raw_evt[i] = link_active ^ link_prev_q;
         end else begin : g_slot
            assign raw_evt[i] = pin_sync[i] & ~pin_prev_q[i];
         end
         // Set wins over a same-cycle clear; pending repeats merge.
         always_comb begin
            status_d[i] = status_q[i];
            if (status_clear[i]) begin
               status_d[i] = 1'b0;
            end
            if (raw_evt[i]) begin
               status_d[i] = 1'b1;
            end
         end
      end
   endgenerate

   // A fresh event is one whose status was clear before.
   assign set_evt = raw_evt & ~status_q;

   // Status storage.
   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt generation.
   // ------------------------------------------------------------------
   logic reen_pulse;
   assign reen_pulse = REENABLE_MSG && hp_int_enable && !hp_en_prev_q
                       && ((status_q & event_enable) != '0);

   // Level and message interrupt outputs.
   always_ff @(posedge clk) begin
      if (rst) begin
         intx_assert <= 1'b0;
         msi_req <= 1'b0;
         hp_en_prev_q <= 1'b0;
      end else begin
         hp_en_prev_q <= hp_int_enable;
         intx_assert <= (int_mode == hpn_pkg::HPN_MODE_INTX) && hp_int_enable
                        && ((status_q & event_enable) != '0);
         msi_req <= (int_mode == hpn_pkg::HPN_MODE_MSI) && hp_int_enable
                    && (((set_evt & event_enable) != '0) || reen_pulse);
      end
   end

   // ------------------------------------------------------------------
   // Wakeup generation, independent of the global interrupt enable.
   // ------------------------------------------------------------------
   logic low_power;
   assign low_power = (dstate != hpn_pkg::HPN_D0) || system_sleep;

   // Wake pulse is built in the port; the adapter needs no power.
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_req <= 1'b0;
      end else begin
         wake_req <= wake_required && low_power && wake_request_enable
                     && ((set_evt & event_enable) != '0);
      end
   end

   // ------------------------------------------------------------------
   // Insertion watchdog: flags a missing link event after one second.
   // ------------------------------------------------------------------
   logic [31:0] ins_cnt_q;
   logic ins_run_q;
   logic ins_trig;
   assign ins_trig = power_ctrl_present ? power_on_cmd : set_evt[`HPN_EV_PRES];

   // The flag only tells software; the link event itself comes from the link.
   always_ff @(posedge clk) begin
      if (rst) begin
         ins_cnt_q <= '0;
         ins_run_q <= 1'b0;
         insert_timeout <= 1'b0;
      end else if (raw_evt[`HPN_EV_LINK]) begin
         ins_run_q <= 1'b0;
         insert_timeout <= 1'b0;
      end else if (ins_trig) begin
         ins_run_q <= 1'b1;
         ins_cnt_q <= '0;
         insert_timeout <= 1'b0;
      end else if (ins_run_q) begin
         if (ins_cnt_q == 32'(INSERT_LIMIT_CYC - 1)) begin
            ins_run_q <= 1'b0;
            insert_timeout <= 1'b1;
         end else begin
            ins_cnt_q <= ins_cnt_q + 32'h1;
         end
      end
   end

   // Mirrored outputs.
   always_ff @(posedge clk) begin
      if (rst) begin
         status <= '0;
         link_active_out <= 1'b0;
      end else begin
         status <= status_d;
         link_active_out <= link_active;
      end
   end

   // ------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------
   property p_link_set;
      @(posedge clk) disable iff (rst)
      (link_active != link_prev_q) |=> status_q[`HPN_EV_LINK];
   endproperty
   a_link_set: assert property (p_link_set) else $error("link change not recorded");

   property p_gate;
      @(posedge clk) disable iff (rst)
      !hp_int_enable |=> !intx_assert && !msi_req;
   endproperty
   a_gate: assert property (p_gate) else $error("interrupt while globally off");

   property p_masked;
      @(posedge clk) disable iff (rst)
      ((status_q & event_enable) == '0) |=> !intx_assert;
   endproperty
   a_masked: assert property (p_masked) else $error("intx without enabled status");

   property p_level;
      @(posedge clk) disable iff (rst)
      (int_mode == hpn_pkg::HPN_MODE_INTX && hp_int_enable
       && (status_q & event_enable) != '0) |=> intx_assert;
   endproperty
   a_level: assert property (p_level) else $error("intx dropped early");

   property p_edge;
      @(posedge clk) disable iff (rst)
      (int_mode == hpn_pkg::HPN_MODE_MSI && hp_int_enable
       && (set_evt & event_enable) != '0) |=> msi_req;
   endproperty
   a_edge: assert property (p_edge) else $error("missing msi");

   property p_no_repeat;
      @(posedge clk) disable iff (rst)
      (hp_en_prev_q && ((raw_evt & ~status_q & event_enable) == '0)) |=> !msi_req;
   endproperty
   a_no_repeat: assert property (p_no_repeat) else $error("msi without fresh event");

   property p_wake;
      @(posedge clk) disable iff (rst)
      (wake_required && wake_request_enable && (dstate != hpn_pkg::HPN_D0)
       && (raw_evt & ~status_q & event_enable) != '0) |=> wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("missing wake");

   property p_wake_d0;
      @(posedge clk) disable iff (rst)
      (!low_power || !wake_request_enable) |=> !wake_req;
   endproperty
   a_wake_d0: assert property (p_wake_d0) else $error("wake outside low power");

   property p_clear;
      @(posedge clk) disable iff (rst)
      (status_clear[0] && !raw_evt[0]) |=> !status_q[0];
   endproperty
   a_clear: assert property (p_clear) else $error("write one did not clear");

   property p_set_wins;
      @(posedge clk) disable iff (rst)
      (status_clear[0] && raw_evt[0]) |=> status_q[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   c_msi: cover property (@(posedge clk) msi_req);
   c_intx: cover property (@(posedge clk) intx_assert);
   c_wake: cover property (@(posedge clk) wake_req);
   c_tmo: cover property (@(posedge clk) insert_timeout);
endmodule
`default_nettype wire

/* File: tb/hpn_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Host side: counts messages and wakes, and keeps software's timing rules.
// ----------------------------------------------------------------------
module hpn_host_model #(
   parameter int CFG_WAIT_CYC = 1000000,
   parameter int BROKEN_WAIT_CYC = 10000000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic msi_req,
   input wire logic wake_req,
   input wire logic link_up,
   input wire logic insert_timeout,
   output logic [7:0] msi_cnt,
   output logic [7:0] wake_cnt,
   output logic cfg_allowed,
   output logic broken_allowed,
   output logic hot_add_abandoned
);
   logic [31:0] up_cnt_q;

   // Software holds back configuration traffic after link-up, and longer before blaming a device.
   always_ff @(posedge clk) begin
      if (rst || !link_up) begin
         up_cnt_q <= 32'h0;
         cfg_allowed <= 1'b0;
         broken_allowed <= 1'b0;
      end else begin
         if (up_cnt_q != 32'hffffffff) begin
            up_cnt_q <= up_cnt_q + 32'h1;
         end
         cfg_allowed <= (up_cnt_q >= 32'(CFG_WAIT_CYC));
         broken_allowed <= (up_cnt_q >= 32'(BROKEN_WAIT_CYC));
      end
   end

   // Software gives up on the hot-add once the insertion timer has run out.
   always_ff @(posedge clk) begin
      if (rst) begin
         hot_add_abandoned <= 1'b0;
      end else if (insert_timeout) begin
         hot_add_abandoned <= 1'b1;
      end
   end

   // Every one-cycle pulse is one message, so a stretched pulse shows up as extra counts.
   always_ff @(posedge clk) begin
      if (rst) begin
         msi_cnt <= 8'h00;
         wake_cnt <= 8'h00;
      end else begin
         msi_cnt <= msi_cnt + {7'h00, msi_req};
         wake_cnt <= wake_cnt + {7'h00, wake_req};
      end
   end
endmodule
`default_nettype wire

/* File: tb/test_hpn_notify.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
// ----------------------------------------------------------------------
// Directed bench for the hot-plug notification logic.
// ----------------------------------------------------------------------
module test_hpn_notify;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic link = 1'b0;
   logic [5:0] pin = 6'h00, en = 6'h3f, clr = 6'h00;
   logic gie = 1'b1, wre = 1'b0, wreq = 1'b1, pcp = 1'b0, pon = 1'b0, slp = 1'b0;
   hpn_pkg::hpn_mode_t mode = hpn_pkg::HPN_MODE_MSI;
   hpn_pkg::hpn_dstate_t ds = hpn_pkg::HPN_D0;
   logic [5:0] st;
   logic lao, intx, msi, wake, tmo, cfg, brk, aban;
   logic [7:0] mc, wc, m0;
   int num_errors = 0, tests_run = 0;
   // Period of 100 ns.
   always #50 clk = ~clk;
   // The insertion limit is shortened to 50 cycles so the timeout case stays quick.
   hpn_notify #(.INSERT_LIMIT_CYC(50)) uut (.clk(clk), .rst(rst), .link_active(link),
      .slot_event_pin(pin), .event_enable(en), .status_clear(clr), .hp_int_enable(gie),
      .int_mode(mode), .dstate(ds), .system_sleep(slp), .wake_request_enable(wre),
      .wake_required(wreq), .power_ctrl_present(pcp), .power_on_cmd(pon), .status(st),
      .link_active_out(lao), .intx_assert(intx), .msi_req(msi), .wake_req(wake),
      .insert_timeout(tmo));
   // Software wait times are shortened the same way as the insertion limit.
   hpn_host_model #(.CFG_WAIT_CYC(10), .BROKEN_WAIT_CYC(20)) host (.clk(clk), .rst(rst),
      .msi_req(msi), .wake_req(wake), .link_up(lao), .insert_timeout(tmo), .msi_cnt(mc),
      .wake_cnt(wc), .cfg_allowed(cfg), .broken_allowed(brk), .hot_add_abandoned(aban));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Outputs are sampled at the falling edge, well clear of register updates.
   task automatic look;
      @(negedge clk);
   endtask
   // A slot level is held past the synchroniser before it drops again.
   task automatic strike(input int i);
      tick(1);
      pin[i] <= 1'b1;
      tick(8);
      pin[i] <= 1'b0;
      tick(4);
      look;
   endtask
   task automatic zap(input logic [5:0] m);
      tick(1);
      clr <= m;
      tick(1);
      clr <= 6'h00;
      tick(2);
      look;
   endtask
   task automatic set_link(input logic v);
      tick(1);
      link <= v;
      tick(3);
      look;
   endtask
   task automatic finish_test;
      $display("errors %0d, comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // A hang costs at most 3000 cycles, several times the whole sequence.
   initial begin
      tick(3000);
      num_errors++;
      finish_test;
   end
   // Main sequence.
   initial begin
      tick(2);
      rst <= 1'b0;
      tick(1);
      look;
      `CHK({st, intx, msi, wake, tmo}, 10'h000)
      m0 = mc;
      set_link(1'b1);
      `CHK(st, 6'h20)
      `CHK(lao, 1'b1)
      `CHK(mc, m0 + 8'h01)
      `CHK(cfg, 1'b0)
      zap(6'h00);
      `CHK(st, 6'h20)
      zap(6'h20);
      `CHK(st, 6'h00)
      set_link(1'b0);
      `CHK(st, 6'h20)
      set_link(1'b1);
      `CHK(mc, m0 + 8'h02)
      zap(6'h20);
      tick(1);
      en <= 6'h3d;
      strike(1);
      `CHK(st, 6'h02)
      `CHK(mc, m0 + 8'h02)
      strike(0);
      `CHK(st, 6'h03)
      `CHK(mc, m0 + 8'h03)
      `CHK({cfg, brk}, 2'b11)
      zap(6'h3f);
      tick(1);
      en <= 6'h3f;
      gie <= 1'b0;
      strike(2);
      `CHK(mc, m0 + 8'h03)
      tick(1);
      gie <= 1'b1;
      tick(3);
      look;
      `CHK(mc, m0 + 8'h04)
      zap(6'h3f);
      tick(1);
      mode <= hpn_pkg::HPN_MODE_INTX;
      strike(3);
      `CHK(intx, 1'b1)
      tick(1);
      gie <= 1'b0;
      tick(2);
      look;
      `CHK(intx, 1'b0)
      tick(1);
      gie <= 1'b1;
      tick(2);
      look;
      `CHK(intx, 1'b1)
      zap(6'h3f);
      `CHK(intx, 1'b0)
      tick(1);
      ds <= hpn_pkg::HPN_D3HOT;
      wre <= 1'b1;
      gie <= 1'b0;
      strike(4);
      `CHK(wc, 8'h01)
      `CHK(intx, 1'b0)
      zap(6'h3f);
      tick(1);
      wre <= 1'b0;
      strike(0);
      `CHK(wc, 8'h01)
      zap(6'h3f);
      tick(1);
      ds <= hpn_pkg::HPN_D0;
      pcp <= 1'b1;
      mode <= hpn_pkg::HPN_MODE_OFF;
      gie <= 1'b1;
      tick(1);
      pon <= 1'b1;
      tick(1);
      pon <= 1'b0;
      // The trigger restarts the timer: still quiet one cycle before the limit of 50.
      tick(49);
      look;
      `CHK(tmo, 1'b0)
      tick(1);
      look;
      `CHK(tmo, 1'b1)
      `CHK(aban, 1'b1)
      tick(1);
      pon <= 1'b1;
      tick(1);
      pon <= 1'b0;
      set_link(1'b0);
      tick(60);
      look;
      `CHK(tmo, 1'b0)
      // With delivery switched off, the recorded link change raises neither kind of interrupt.
      `CHK({st, intx, mc}, {6'h20, 1'b0, m0 + 8'h04})
      finish_test;
   end
endmodule
`default_nettype wire
